/* actmr_top.v */
// alarm, pause and interrupt section of a 64-bit microsecond timer with an AXI4-Lite slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "actmr_regs.vh"

module actmr_top (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // shared reference tick and debug state
  input  wire        tick_in,
  input  wire        cpu0_debug,
  input  wire        cpu1_debug,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // interrupt
  output reg         timer_irq
);

  // ***********************************************************************
  // state
  // ***********************************************************************
  reg  [63:0] time_count;
  reg  [31:0] lower_hold;
  reg  [31:0] upper_latch;
  reg  [1:0]  debug_halt_mask;
  reg         software_halt;
  reg  [3:0]  irq_raw_flags;
  reg  [3:0]  irq_enable_mask;
  reg  [3:0]  irq_force_mask;
  reg  [7:0]  wr_addr;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;

  wire [31:0] alarm_target [0:3];
  wire [3:0]  armed;
  wire [3:0]  fire;
  wire [3:0]  irq_masked_status;
  wire [31:0] wmask;
  wire [31:0] wbits;
  wire        do_wr;
  wire        halted;

  // ***********************************************************************
  // write channel: address and data are taken in either order
  // ***********************************************************************
  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // byte enables widen to a bit mask so partial writes merge correctly
  assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wbits = wr_data & wmask;

  // address and data holders, released together once the write lands
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      wr_addr       <= 8'h00;
      wr_data       <= `ACTMR_RST_WORD;
      wr_strb       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_wr) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_wr) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write decode: one hit per mapped word, anything else answers slverr
  reg wr_hit;
  reg wr_alarm_any;
  always @* begin
    wr_hit       = 1'b0;
    wr_alarm_any = 1'b0;
    case (wr_addr)
      `ACTMR_TIME_UPPER_WRITE,
      `ACTMR_TIME_LOWER_WRITE,
      `ACTMR_ALARM_ARM_STATUS,
      `ACTMR_DEBUG_HALT_MASK,
      `ACTMR_SOFTWARE_HALT,
      `ACTMR_IRQ_RAW_FLAGS,
      `ACTMR_IRQ_ENABLE_MASK,
      `ACTMR_IRQ_FORCE_MASK: wr_hit = 1'b1;
      `ACTMR_ALARM_ZERO_COMPARE,
      `ACTMR_ALARM_ONE_COMPARE,
      `ACTMR_ALARM_TWO_COMPARE,
      `ACTMR_ALARM_THREE_COMPARE: begin
        wr_hit       = 1'b1;
        wr_alarm_any = 1'b1;
      end
      // read-only words accept the write and ignore it
      `ACTMR_TIME_UPPER_LATCHED,
      `ACTMR_TIME_LOWER_LATCHED,
      `ACTMR_TIME_UPPER_UNLATCH,
      `ACTMR_TIME_LOWER_UNLATCH,
      `ACTMR_IRQ_MASKED_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response follows the write by one edge
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ACTMR_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `ACTMR_RESP_OKAY : `ACTMR_RESP_SLVERR;
    end else if (s_axi_bready && s_axi_bvalid) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ***********************************************************************
  // control registers
  // ***********************************************************************
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      debug_halt_mask <= `ACTMR_RST_DEBUG_HALT;
      software_halt   <= `ACTMR_RST_SOFTWARE_HALT;
      irq_enable_mask <= `ACTMR_RST_ALARM_BITS;
      irq_force_mask  <= `ACTMR_RST_ALARM_BITS;
    end else if (do_wr) begin
      if (wr_addr == `ACTMR_DEBUG_HALT_MASK && wr_strb[0]) begin
        debug_halt_mask <= {wr_data[`ACTMR_CPU1_DEBUG_HALT_EN], wr_data[`ACTMR_CPU0_DEBUG_HALT_EN]};
      end
      if (wr_addr == `ACTMR_SOFTWARE_HALT && wr_strb[0]) begin
        software_halt <= wr_data[`ACTMR_SOFTWARE_HALT_BIT];
      end
      if (wr_addr == `ACTMR_IRQ_ENABLE_MASK && wr_strb[0]) begin
        irq_enable_mask <= wr_data[3:0];
      end
      if (wr_addr == `ACTMR_IRQ_FORCE_MASK && wr_strb[0]) begin
        irq_force_mask <= wr_data[3:0];
      end
    end
  end

  // ***********************************************************************
  // time counter
  // ***********************************************************************
  // any pause source freezes the count
  assign halted = software_halt ||
                  (debug_halt_mask[0] && cpu0_debug) ||
                  (debug_halt_mask[1] && cpu1_debug);

  // a 64-bit load beats a tick in the same cycle so software sees its value
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      time_count <= 64'h0000000000000000;
      lower_hold <= `ACTMR_RST_WORD;
    end else begin
      if (do_wr && wr_addr == `ACTMR_TIME_LOWER_WRITE) begin
        lower_hold <= (lower_hold & ~wmask) | wbits;
      end
      if (do_wr && wr_addr == `ACTMR_TIME_UPPER_WRITE) begin
        time_count <= {(time_count[63:32] & ~wmask) | wbits, lower_hold};
      end else if (tick_in && !halted) begin
        time_count <= time_count + 64'h0000000000000001;
      end
    end
  end

  // ***********************************************************************
  // alarms
  // ***********************************************************************
  genvar g;
  generate
    for (g = 0; g < `ACTMR_NUM_ALARMS; g = g + 1) begin : g_alarm
      wire load_sel;
      wire disarm_sel;
      // compare word at base plus four per alarm
      assign load_sel   = do_wr && wr_alarm_any && ({30'h0, wr_addr[3:2]} == g);
      assign disarm_sel = do_wr && (wr_addr == `ACTMR_ALARM_ARM_STATUS) && wbits[g];
      actmr_alarm u_alarm (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (load_sel),
        .wdata   (wr_data),
        .wmask   (wmask),
        .disarm  (disarm_sel),
        .time_lo (time_count[31:0]),
        .target  (alarm_target[g]),
        .armed   (armed[g]),
        .fire    (fire[g])
      );
    end
  endgenerate

  // ***********************************************************************
  // interrupts
  // ***********************************************************************
  // raw flags: a fire landing with a clear of the same bit stays set
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_raw_flags <= `ACTMR_RST_ALARM_BITS;
    end else begin
      irq_raw_flags <= (irq_raw_flags & ~((do_wr && wr_addr == `ACTMR_IRQ_RAW_FLAGS) ? wbits[3:0] : 4'h0))
                       | fire;
    end
  end

  assign irq_masked_status = (irq_raw_flags & irq_enable_mask) | irq_force_mask;

  // registered line costs one cycle of latency but keeps the pin glitch free
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |irq_masked_status;
    end
  end

  // ***********************************************************************
  // read channel
  // ***********************************************************************
  reg [31:0] rd_word;
  reg        rd_hit;
  always @* begin
    rd_word = `ACTMR_RST_WORD;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `ACTMR_TIME_UPPER_WRITE,
      `ACTMR_TIME_LOWER_WRITE:    rd_word = `ACTMR_RST_WORD;
      `ACTMR_TIME_UPPER_LATCHED:  rd_word = upper_latch;
      `ACTMR_TIME_LOWER_LATCHED:  rd_word = time_count[31:0];
      `ACTMR_ALARM_ZERO_COMPARE:  rd_word = alarm_target[0];
      `ACTMR_ALARM_ONE_COMPARE:   rd_word = alarm_target[1];
      `ACTMR_ALARM_TWO_COMPARE:   rd_word = alarm_target[2];
      `ACTMR_ALARM_THREE_COMPARE: rd_word = alarm_target[3];
      `ACTMR_ALARM_ARM_STATUS:    rd_word = {28'h0000000, armed};
      `ACTMR_TIME_UPPER_UNLATCH:  rd_word = time_count[63:32];
      `ACTMR_TIME_LOWER_UNLATCH:  rd_word = time_count[31:0];
      `ACTMR_DEBUG_HALT_MASK:     rd_word = {29'h00000000, debug_halt_mask, 1'b0};
      `ACTMR_SOFTWARE_HALT:       rd_word = {31'h00000000, software_halt};
      `ACTMR_IRQ_RAW_FLAGS:       rd_word = {28'h0000000, irq_raw_flags};
      `ACTMR_IRQ_ENABLE_MASK:     rd_word = {28'h0000000, irq_enable_mask};
      `ACTMR_IRQ_FORCE_MASK:      rd_word = {28'h0000000, irq_force_mask};
      `ACTMR_IRQ_MASKED_STATUS:   rd_word = {28'h0000000, irq_masked_status};
      default:                    rd_hit  = 1'b0;
    endcase
  end

  // one read under way at a time; data is sampled at address acceptance
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `ACTMR_RST_WORD;
      s_axi_rresp   <= `ACTMR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? `ACTMR_RESP_OKAY : `ACTMR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // only the latched lower read disturbs state; raw reads never touch the latch
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      upper_latch <= `ACTMR_RST_WORD;
    end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `ACTMR_TIME_LOWER_LATCHED) begin
      upper_latch <= time_count[63:32];
    end
  end

endmodule // actmr_top

/* actmr_regs.vh */
// register map, field positions, reset values and timing figures of the alarm timer
`ifndef ACTMR_REGS_VH
`define ACTMR_REGS_VH

// ***********************************************************************
// register byte offsets
// ***********************************************************************
`define ACTMR_TIME_UPPER_WRITE    8'h00
`define ACTMR_TIME_LOWER_WRITE    8'h04
`define ACTMR_TIME_UPPER_LATCHED  8'h08
`define ACTMR_TIME_LOWER_LATCHED  8'h0C
`define ACTMR_ALARM_ZERO_COMPARE  8'h10
`define ACTMR_ALARM_ONE_COMPARE   8'h14
`define ACTMR_ALARM_TWO_COMPARE   8'h18
`define ACTMR_ALARM_THREE_COMPARE 8'h1C
`define ACTMR_ALARM_ARM_STATUS    8'h20
`define ACTMR_TIME_UPPER_UNLATCH  8'h24
`define ACTMR_TIME_LOWER_UNLATCH  8'h28
`define ACTMR_DEBUG_HALT_MASK     8'h2C
`define ACTMR_SOFTWARE_HALT       8'h30
`define ACTMR_IRQ_RAW_FLAGS       8'h34
`define ACTMR_IRQ_ENABLE_MASK     8'h38
`define ACTMR_IRQ_FORCE_MASK      8'h3C
`define ACTMR_IRQ_MASKED_STATUS   8'h40

// ***********************************************************************
// field positions and sizes
// ***********************************************************************
`define ACTMR_NUM_ALARMS          4
`define ACTMR_CPU0_DEBUG_HALT_EN  1
`define ACTMR_CPU1_DEBUG_HALT_EN  2
`define ACTMR_SOFTWARE_HALT_BIT   0

// ***********************************************************************
// reset values
// ***********************************************************************
`define ACTMR_RST_WORD            32'h00000000
`define ACTMR_RST_ALARM_BITS      4'h0
`define ACTMR_RST_DEBUG_HALT      2'h3
`define ACTMR_RST_SOFTWARE_HALT   1'h0

// ***********************************************************************
// bus responses
// ***********************************************************************
`define ACTMR_RESP_OKAY           2'h0
`define ACTMR_RESP_SLVERR         2'h2

// ***********************************************************************
// timing: the time counter steps once per shared tick, nominally 1 us
// ***********************************************************************
`define ACTMR_TICK_PERIOD_NS      1000
`define ACTMR_CLK_PERIOD_NS       5
`define ACTMR_CYCLES_PER_TICK     (`ACTMR_TICK_PERIOD_NS / `ACTMR_CLK_PERIOD_NS)

`endif

/* actmr_alarm.v */
// one compare alarm: target register, armed flag and fire pulse
`timescale 1ns/1ps
`include "actmr_regs.vh"

module actmr_alarm (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // register access
  input  wire        load,
  input  wire [31:0] wdata,
  input  wire [31:0] wmask,
  input  wire        disarm,
  // running time
  input  wire [31:0] time_lo,
  // state
  output reg  [31:0] target,
  output reg         armed,
  output reg         fire
);

  // ***********************************************************************
  // compare and arm
  // ***********************************************************************
  wire match;

  assign match = armed && (target == time_lo);

  // a fresh load wins over a match in the same cycle; a disarm write
  // suppresses a match that lands on the same edge
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      target <= `ACTMR_RST_WORD;
      armed  <= 1'b0;
      fire   <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (load) begin
        target <= (target & ~wmask) | (wdata & wmask);
        armed  <= 1'b1;
      end else if (disarm) begin
        armed <= 1'b0;
      end else if (match) begin
        fire  <= 1'b1;
        armed <= 1'b0;
      end
    end
  end

endmodule // actmr_alarm

/* actmr_check_sva.sv */
// assertion checker on the bus and interrupt ports of the alarm timer
`timescale 1ns/1ps
module actmr_check (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // interrupt
  input wire logic        timer_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // address of the read in flight, so reserved bits are judged per word
  logic [7:0] rd_addr;
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      rd_addr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr <= s_axi_araddr;
  end
  // ********************
  // assertions
  // ********************
  reset_quiet_a: assert property (
    $rose(rst_n) |-> !timer_irq && !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
    else $error("bus or interrupt busy after reset");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  armed_bits_a: assert property (
    s_axi_rvalid && rd_addr == 8'h20 |-> s_axi_rdata[31:4] == 28'h0)
    else $error("armed status reserved bits set");
  irq_bits_a: assert property (
    s_axi_rvalid && rd_addr >= 8'h34 && rd_addr <= 8'h40 |-> s_axi_rdata[31:4] == 28'h0)
    else $error("interrupt word reserved bits set");
  halt_bits_a: assert property (
    s_axi_rvalid && rd_addr == 8'h30 |-> s_axi_rdata[31:1] == 31'h0)
    else $error("halt word reserved bits set");
  force_irq_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h3C && s_axi_wvalid && s_axi_wready
      && s_axi_wstrb[0] && s_axi_wdata[3:0] != 4'h0 |-> ##[1:4] timer_irq)
    else $error("forced interrupt not raised");
  // main scenarios reached
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($rose(timer_irq));
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule // actmr_check

bind actmr_top actmr_check u_actmr_check (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_irq(timer_irq)
);

/* actmr_tb_top.sv */
// self-checking bench for the alarm, pause and interrupt timer block
`timescale 1ns/1ps
module actmr_tb_top;
  // ********************
  // signals and design
  // ********************
  logic        ref_clk = 1'b0, rst_n = 1'b0, tick_in = 1'b0, cpu0_debug = 1'b0, cpu1_debug = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  int          failures = 0, total_checks = 0, wait_cnt, n, k;
  logic [31:0] hi, lo, d;
  logic [63:0] t64;
  logic [1:0]  resp;

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  actmr_top u_actmr_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .tick_in(tick_in), .cpu0_debug(cpu0_debug), .cpu1_debug(cpu1_debug),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_irq(timer_irq)
  );

  // ********************
  // tasks and expectations
  // ********************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // one clock with a bound, so a silent slave cannot hang the run
  task automatic step();
    @(posedge ref_clk);
    wait_cnt++;
    if (wait_cnt > 100) begin
      failures++;
      give_verdict();
    end
  endtask

  // write: address and data offered together, response taken after a random stall
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    wait_cnt = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      step();
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat ($urandom_range(2, 0)) step();
    s_axi_bready <= 1'b1;
    do step(); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    wait_cnt = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do step(); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2, 0)) step();
    s_axi_rready <= 1'b1;
    do step(); while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] r;
    axi_wr(a, v, r);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  r;
    axi_rd(a, v, r);
    chk(v, exp);
  endtask

  // shared tick pulses, one clock high each
  task automatic ticks(input int cnt);
    repeat (cnt) begin
      @(posedge ref_clk) tick_in <= 1'b1;
      @(posedge ref_clk) tick_in <= 1'b0;
    end
  endtask

  // low word first: it is held until the upper write loads both
  task automatic load_time(input logic [31:0] h, input logic [31:0] l);
    wr(8'h04, l);
    wr(8'h00, h);
  endtask

  function automatic logic [3:0] irq_status(input logic [3:0] raw, input logic [3:0] en, input logic [3:0] frc);
    return (raw & en) | frc;
  endfunction

  // ********************
  // test sequence
  // ********************
  initial begin
    void'($urandom(40));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, read-only status and a refused address
    rc(8'h20, 32'h00000000);
    rc(8'h2C, 32'h00000006);
    rc(8'h30, 32'h00000000);
    for (k = 0; k < 4; k++) rc(8'h34 + 8'(4 * k), 32'h00000000);
    wr(8'h40, 32'hFFFFFFFF);
    rc(8'h40, 32'h00000000);
    axi_wr(8'h44, 32'hFFFFFFFF, resp);
    chk(32'(resp), 32'h00000002);
    axi_rd(8'h44, d, resp);
    chk({d[29:0], resp}, 32'h00000002);
    // byte lanes: a partial compare write merges, a control write without lane 0 is ignored
    d = $urandom | 32'h80000000;
    wr(8'h10, d);
    s_axi_wstrb <= 4'h3;
    wr(8'h10, ~d);
    s_axi_wstrb <= 4'hE;
    wr(8'h3C, 32'hFFFFFFFF);
    s_axi_wstrb <= 4'hF;
    rc(8'h10, {d[31:16], ~d[15:0]});
    rc(8'h3C, 32'h00000000);
    wr(8'h20, 32'h00000001);
    rc(8'h20, 32'h00000000);
    // time load, side-effect-free reads, counting with a carry corner
    for (k = 0; k < 3; k++) begin
      hi = $urandom;
      lo = (k == 0) ? 32'hFFFFFFFD : $urandom;
      n = (k == 0) ? 5 : $urandom_range(15, 1);
      load_time(hi, lo);
      rc(8'h28, lo);
      rc(8'h28, lo);
      rc(8'h24, hi);
      ticks(n);
      t64 = {hi, lo} + 64'(n);
      rc(8'h0C, t64[31:0]);
      // a new upper half after the low read must not reach the latch
      load_time(~t64[63:32], lo);
      rc(8'h24, ~t64[63:32]);
      rc(8'h08, t64[63:32]);
    end
    // software and debug pause hold the time still
    load_time(32'h00000000, 32'h00000100);
    wr(8'h30, 32'h00000001);
    ticks(3);
    rc(8'h28, 32'h00000100);
    wr(8'h30, 32'h00000000);
    cpu0_debug <= 1'b1;
    ticks(3);
    rc(8'h28, 32'h00000100);
    cpu0_debug <= 1'b0;
    cpu1_debug <= 1'b1;
    ticks(3);
    rc(8'h28, 32'h00000100);
    // only the cpu 0 enable left set: cpu 1 in debug no longer pauses
    wr(8'h2C, 32'h00000002);
    rc(8'h2C, 32'h00000002);
    ticks(2);
    rc(8'h28, 32'h00000102);
    cpu1_debug <= 1'b0;
    // each alarm: arm, fire, interrupt mask and force, clear, early disarm
    for (k = 0; k < 4; k++) begin
      lo = $urandom;
      n = $urandom_range(6, 1);
      load_time(32'h00000000, lo);
      wr(8'h10 + 8'(4 * k), lo + n);
      rc(8'h10 + 8'(4 * k), lo + n);
      rc(8'h20, 32'(1 << k));
      wr(8'h38, 32'(1 << k));
      ticks(n - 1);
      rc(8'h34, 32'h00000000);
      ticks(1);
      repeat (4) @(posedge ref_clk);
      rc(8'h20, 32'h00000000);
      rc(8'h34, 32'(1 << k));
      rc(8'h40, 32'(irq_status(4'(1 << k), 4'(1 << k), 4'h0)));
      chk(32'(timer_irq), 32'h00000001);
      wr(8'h38, 32'h00000000);
      rc(8'h40, 32'h00000000);
      chk(32'(timer_irq), 32'h00000000);
      wr(8'h3C, 32'(1 << k));
      rc(8'h40, 32'(irq_status(4'(1 << k), 4'h0, 4'(1 << k))));
      chk(32'(timer_irq), 32'h00000001);
      wr(8'h3C, 32'h00000000);
      wr(8'h34, 32'(1 << k));
      rc(8'h34, 32'h00000000);
      wr(8'h10 + 8'(4 * k), lo + n + 2);
      wr(8'h20, 32'(1 << k));
      rc(8'h20, 32'h00000000);
      ticks(2);
      repeat (4) @(posedge ref_clk);
      rc(8'h34, 32'h00000000);
    end
    // mid-run reset with a forced interrupt standing: all returns to reset values
    wr(8'h3C, 32'h0000000F);
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(32'(timer_irq), 32'h00000000);
    rc(8'h3C, 32'h00000000);
    rc(8'h2C, 32'h00000006);
    rc(8'h28, 32'h00000000);
    give_verdict();
  end

  // watchdog: the sequence needs about a thousand cycles, this allows 20000
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule // actmr_tb_top
